// [src/pwm_wave_counter_defs.svh]
// Purpose: Register offsets, field positions and reset values of the wave counter.
// Assumes: APB with 32-bit data and 12-bit byte addresses.
// Notes:   Included by the wave counter module, its checker and the bench.
`ifndef PWM_WAVE_COUNTER_DEFS_SVH
`define PWM_WAVE_COUNTER_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define PWM_ADDR_CTRL      12'h000
`define PWM_ADDR_PRESCALE  12'h004
`define PWM_ADDR_TOP       12'h008
`define PWM_ADDR_TASK      12'h00C
`define PWM_ADDR_STATUS    12'h010

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PWM_CTRL_UPDOWN    0
`define PWM_CTRL_LOAD_LO   1
`define PWM_CTRL_LOAD_HI   2
`define PWM_TASK_BEGIN     0
`define PWM_TASK_STOP      1
`define PWM_STAT_RUN       0
`define PWM_STAT_DOWN      1
`define PWM_STAT_OUT_LO    4
`define PWM_STAT_OUT_HI    7
`define PWM_STAT_CNT_LO    16
`define PWM_STAT_CNT_HI    30

// ----------------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------------
`define PWM_LOAD_LAYOUT_A  2'h3
`define PWM_TOP_CHAN       2'h3
`define PWM_RST_TOP        15'h03E8
`define PWM_RST_WORD       32'h0000_0000

`endif

// [src/pwm_pkg.sv]
// Purpose: Types shared by the wave counter and its bench.
// Assumes: Constants live in pwm_wave_counter_defs.svh.
// Notes:   Duty words carry polarity in the top bit.
package pwm_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [0:0] {
    PWM_ST_IDLE = 1'b0,
    PWM_ST_RUN  = 1'b1
  } pwm_state_e;

  typedef struct packed {
    logic        pol;
    logic [14:0] cmp;
  } pwm_duty_s;

  typedef struct packed {
    logic      valid;
    logic      commit;
    logic [1:0] chan;
    pwm_duty_s word;
  } pwm_fetch_s;

endpackage : pwm_pkg

// [src/pwm_wave_counter.sv]
// Purpose: Shared 15-bit wave counter with four compare channels and an APB slave.
// Assumes: The fetch decoder runs on mclk and presents one duty word per cycle.
// Notes:   Compare values reach the block only through the fetch port.
// Notes on behaviour
// - One shared 15-bit counter, four compare channels.
// - Each channel drives its own pin; layout A holds pin 3 low.
// - Direction setting selects up or up-down.
// - Top value and divider set the period.
// - Compare above top gives no edges.
// - Compare values load only via decoder.
// - Top value writable any time safely.
// - Layout A takes top from fetched data.
// - Otherwise top sampled at begin and fetch.
// - Up mode wraps at top, outputs invert.
// - Compare zero low, compare top high in up mode; here polarity 1 only, polarity 0 gives the reverse.
// - Up mode pulses are edge aligned.
// - Up period is top prescaled ticks.
// - Up-down turns downward at top.
// - Up-down inverts on down match, centered.
// - Up-down period twice top ticks.
// - Polarity comes from the fetched word.
// - Fetched updates glitch free, no processor.
// - Settings may change every period.
// - Duty word: polarity bit 15, compare below.
// - Polarity 0 rising first, 1 falling first.
//
// The APB slave port and the address map were chosen for this implementation.
`include "pwm_wave_counter_defs.svh"

module pwm_wave_counter #(
  parameter int PRESC_W = 3
) (
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire pwm_pkg::pwm_fetch_s fetch,
  output logic                    period_start,
  output logic      [3:0]         pwm_out
);

  // The prescaler select field must fit the divider mask arithmetic.
  if (PRESC_W < 1 || PRESC_W > 4)
  begin : g_presc_check
    $error("PRESC_W must lie between 1 and 4.");
  end

  localparam int DIV_W = 1 << PRESC_W;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function automatic logic [DIV_W-1:0] div_mask(input logic [PRESC_W-1:0] sel);
    div_mask = DIV_W'((DIV_W+1)'(1) << sel) - DIV_W'(1);
  endfunction : div_mask

  // Level of one channel; falling first means high until the compare match.
  function automatic logic chan_level(input pwm_pkg::pwm_duty_s d,
                                      input logic [14:0]        cnt);
    chan_level = d.pol ? (cnt < d.cmp) : !(cnt < d.cmp);
  endfunction : chan_level

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic                 updown_q;
  logic [1:0]           layout_q;
  logic [PRESC_W-1:0]   presc_q;
  logic [14:0]          top_reg_q;
  logic                 begin_q;
  logic                 stop_req_q;
  logic                 wr_en;
  logic                 rd_hit;
  logic [31:0]          rd_val;
  pwm_pkg::pwm_state_e  state_q;
  logic                 dir_down_q;
  logic [14:0]          cnt_q;

  assign wr_en = psel && penable && pready && pwrite;

  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = `PWM_RST_WORD;
    unique case (paddr)
      `PWM_ADDR_CTRL:
      begin
        rd_val[`PWM_CTRL_UPDOWN] = updown_q;
        rd_val[`PWM_CTRL_LOAD_HI:`PWM_CTRL_LOAD_LO] = layout_q;
      end
      `PWM_ADDR_PRESCALE: rd_val[PRESC_W-1:0] = presc_q;
      `PWM_ADDR_TOP:      rd_val[14:0] = top_reg_q;
      `PWM_ADDR_TASK:     rd_val = `PWM_RST_WORD;
      `PWM_ADDR_STATUS:
      begin
        rd_val[`PWM_STAT_RUN] = (state_q == pwm_pkg::PWM_ST_RUN);
        rd_val[`PWM_STAT_DOWN] = dir_down_q;
        rd_val[`PWM_STAT_OUT_HI:`PWM_STAT_OUT_LO] = pwm_out;
        rd_val[`PWM_STAT_CNT_HI:`PWM_STAT_CNT_LO] = cnt_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Every access waits exactly one cycle in the access phase.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `PWM_RST_WORD;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !rd_hit;
      prdata  <= (psel && penable && !pready && !pwrite) ? rd_val : `PWM_RST_WORD;
    end
  end

  // Settings are only staged here; the counter adopts them at begin or at a boundary after a commit.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      updown_q  <= 1'b0;
      layout_q  <= 2'h0;
      presc_q   <= '0;
      top_reg_q <= `PWM_RST_TOP;
    end
    else if (wr_en)
    begin
      if (paddr == `PWM_ADDR_CTRL)
      begin
        updown_q <= pwdata[`PWM_CTRL_UPDOWN];
        layout_q <= pwdata[`PWM_CTRL_LOAD_HI:`PWM_CTRL_LOAD_LO];
      end
      if (paddr == `PWM_ADDR_PRESCALE)
      begin
        presc_q <= pwdata[PRESC_W-1:0];
      end
      if (paddr == `PWM_ADDR_TOP)
      begin
        top_reg_q <= pwdata[14:0];
      end
    end
  end

  // A begin write becomes a one-cycle strobe; a stop request is held until the period end.
  logic boundary;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      begin_q    <= 1'b0;
      stop_req_q <= 1'b0;
    end
    else
    begin
      begin_q <= wr_en && (paddr == `PWM_ADDR_TASK) && pwdata[`PWM_TASK_BEGIN];
      if (wr_en && (paddr == `PWM_ADDR_TASK) && pwdata[`PWM_TASK_STOP])
      begin
        stop_req_q <= 1'b1;
      end
      else if (begin_q || (boundary && state_q == pwm_pkg::PWM_ST_RUN))
      begin
        stop_req_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Fetch port: shadow duty words and pending flag
  // --------------------------------------------------------------------------
  pwm_pkg::pwm_duty_s shadow_q [4];
  pwm_pkg::pwm_duty_s active_q [4];
  logic               pend_q;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        shadow_q[i] <= '0;
      end
    end
    else if (fetch.valid)
    begin
      shadow_q[fetch.chan] <= fetch.word;
    end
  end

  // A commit that lands on the boundary cycle stays pending.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pend_q <= 1'b0;
    end
    else if (fetch.commit)
    begin
      pend_q <= 1'b1;
    end
    else if (boundary || begin_q)
    begin
      pend_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Prescaler and shared counter
  // --------------------------------------------------------------------------
  logic [DIV_W-1:0]   pre_q;
  logic [PRESC_W-1:0] presc_act_q;
  logic               tick;
  logic               mode_ud_q;
  logic               layout_a_q;
  logic [14:0]        top_q;
  logic [14:0]        top_next;
  logic               run;

  assign run  = (state_q == pwm_pkg::PWM_ST_RUN);
  assign tick = run && (pre_q == div_mask(presc_act_q));

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pre_q <= '0;
    end
    else if (begin_q || !run || tick)
    begin
      pre_q <= '0;
    end
    else
    begin
      pre_q <= pre_q + DIV_W'(1);
    end
  end

  // End of a period: up wrap, bottom of up-down, or a zero top.
  always_comb
  begin
    if (top_q == 15'h0000)
    begin
      boundary = tick;
    end
    else if (!mode_ud_q)
    begin
      boundary = tick && ({1'b0, cnt_q} + 16'h0001 >= {1'b0, top_q});
    end
    else
    begin
      boundary = tick && dir_down_q && (cnt_q == 15'h0001);
    end
  end

  // Layout A takes its top from the fourth fetched word, otherwise the register.
  always_comb
  begin
    if (layout_q == `PWM_LOAD_LAYOUT_A)
    begin
      top_next = shadow_q[`PWM_TOP_CHAN].cmp;
    end
    else
    begin
      top_next = top_reg_q;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= pwm_pkg::PWM_ST_IDLE;
    end
    else if (begin_q)
    begin
      state_q <= pwm_pkg::PWM_ST_RUN;
    end
    else if (boundary && stop_req_q)
    begin
      state_q <= pwm_pkg::PWM_ST_IDLE;
    end
  end

  // Period-wide settings are adopted together so no period is altered midway.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      top_q       <= `PWM_RST_TOP;
      mode_ud_q   <= 1'b0;
      layout_a_q  <= 1'b0;
      presc_act_q <= '0;
      for (int i = 0; i < 4; i++)
      begin
        active_q[i] <= '0;
      end
    end
    else if (begin_q || (boundary && (pend_q || fetch.commit)))
    begin
      top_q       <= top_next;
      mode_ud_q   <= updown_q;
      layout_a_q  <= (layout_q == `PWM_LOAD_LAYOUT_A);
      presc_act_q <= presc_q;
      for (int i = 0; i < 4; i++)
      begin
        active_q[i] <= shadow_q[i];
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q      <= 15'h0000;
      dir_down_q <= 1'b0;
    end
    else if (begin_q || boundary)
    begin
      cnt_q      <= 15'h0000;
      dir_down_q <= 1'b0;
    end
    else if (tick)
    begin
      if (!mode_ud_q)
      begin
        cnt_q <= cnt_q + 15'h0001;
      end
      else if (!dir_down_q)
      begin
        cnt_q <= cnt_q + 15'h0001;
        if (cnt_q + 15'h0001 >= top_q)
        begin
          dir_down_q <= 1'b1;
        end
      end
      else
      begin
        cnt_q <= cnt_q - 15'h0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Channel outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pwm_out      <= 4'h0;
      period_start <= 1'b0;
    end
    else
    begin
      period_start <= begin_q || boundary;
      for (int i = 0; i < 4; i++)
      begin
        if (!run || (layout_a_q && i == 3))
        begin
          pwm_out[i] <= 1'b0;
        end
        else
        begin
          pwm_out[i] <= chan_level(active_q[i], cnt_q);
        end
      end
    end
  end

endmodule : pwm_wave_counter

// [verification/pwm_wave_counter_checker.sv]
// Purpose: Port assertions for the wave counter.
// Assumes: One clock, mclk; reset sys_rst.
// Notes:   Bound into every wave counter.
`include "pwm_wave_counter_defs.svh"
module pwm_wave_counter_checker (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        period_start,
  input wire logic [3:0]  pwm_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---
  // Properties
  // ---
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_begin_wr;
    psel && penable && pready && pwrite && paddr == `PWM_ADDR_TASK && pwdata[0];
  endsequence
  property p_mapped_ok;
    pready && paddr <= `PWM_ADDR_STATUS && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  property p_task_zero;
    pready && paddr == `PWM_ADDR_TASK |-> prdata == 32'h0000_0000;
  endproperty
  a_ready_second: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_unmapped_err: assert property (pready && paddr > `PWM_ADDR_STATUS |-> pslverr)
    else $error("no error on unmapped");
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("error on mapped");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  a_task_reads_zero: assert property (p_task_zero)
    else $error("task reads nonzero");
  a_begin_start: assert property (s_begin_wr |-> ##2 period_start)
    else $error("no period start after begin");
  a_reset_quiet: assert property ($fell(sys_rst) |-> pwm_out == 4'h0 && !period_start)
    else $error("outputs active after reset");
endmodule : pwm_wave_counter_checker

bind pwm_wave_counter pwm_wave_counter_checker u_pwm_wave_counter_checker (
  .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .period_start(period_start), .pwm_out(pwm_out));

// [verification/pwm_pin_model.sv]
// Purpose: Output pins; measures each period.
// Assumes: Levels lag period_start by one cycle.
// Notes:   Results update as a new period begins.
module pwm_pin_model (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       period_start,
  input  wire logic [3:0] pwm_out,
  output logic     [15:0] len_q,
  output logic     [15:0] hi_q [4]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        mark_q;
  logic [15:0] run_q;
  logic [15:0] acc_q [4];
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mark_q <= 1'b0;
      run_q  <= 16'h0000;
      len_q  <= 16'h0000;
      acc_q  <= '{default: 16'h0000};
      hi_q   <= '{default: 16'h0000};
    end
    else
    begin
      mark_q <= period_start;
      run_q  <= mark_q ? 16'h0001 : run_q + 16'h0001;
      if (mark_q)
        len_q <= run_q;
      for (int i = 0; i < 4; i++)
      begin
        acc_q[i] <= (mark_q ? 16'h0000 : acc_q[i]) + 16'(pwm_out[i]);
        if (mark_q)
          hi_q[i] <= acc_q[i];
      end
    end
  end
endmodule : pwm_pin_model

// [verification/tb.sv]
// Purpose: Self-checking bench for the wave counter.
// Assumes: Fetch words are driven directly.
// Notes:   High counts come from the pin model.
`include "pwm_wave_counter_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                mclk = 1'b0;
  logic                sys_rst = 1'b1;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [11:0]         paddr = 12'h000;
  logic [31:0]         pwdata = 32'h0000_0000;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  pwm_pkg::pwm_fetch_s fetch = '0;
  logic                period_start;
  logic [3:0]          pwm_out;
  logic [15:0]         len_q;
  logic [15:0]         hi_q [4];
  logic [31:0]         rdat;
  logic                rerr;
  int                  mismatches = 0;
  int                  samples_checked = 0;

  always #25 mclk = ~mclk;

  pwm_wave_counter #(.PRESC_W(3)) u_pwm_wave_counter (.mclk(mclk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fetch(fetch),
    .period_start(period_start), .pwm_out(pwm_out));
  pwm_pin_model u_pwm_pin_model (.mclk(mclk), .sys_rst(sys_rst),
    .period_start(period_start), .pwm_out(pwm_out), .len_q(len_q), .hi_q(hi_q));

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps the next setup from reassigning psel in this step.
    @(posedge mclk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", exp, rdat);
    chk("pslverr", {31'h0, err}, {31'h0, rerr});
  endtask : rd

  task automatic load(input logic [1:0] ch, input logic [15:0] w);
    fetch <= {1'b1, 1'b0, ch, w};
    @(posedge mclk);
  endtask : load

  task automatic commit();
    fetch <= {1'b0, 1'b1, 2'h0, 16'h0000};
    @(posedge mclk);
    fetch <= '0;
  endtask : commit

  task automatic meas(input int n, input logic [15:0] len, input logic [63:0] h);
    repeat (n) @(posedge mclk iff period_start);
    repeat (2) @(posedge mclk);
    chk("period", {16'h0, len}, {16'h0, len_q});
    for (int i = 0; i < 4; i++)
      chk("high", {16'h0, h[16*i +: 16]}, {16'h0, hi_q[i]});
  endtask : meas

  initial
  begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(`PWM_ADDR_CTRL, 32'h0000_0000, 1'b0);
    rd(`PWM_ADDR_TOP, 32'h0000_03E8, 1'b0);
    rd(12'h020, 32'h0000_0000, 1'b1);
    apb(1'b1, `PWM_ADDR_STATUS, 32'hFFFF_FFFF);
    rd(`PWM_ADDR_STATUS, 32'h0000_0000, 1'b0);
    apb(1'b1, `PWM_ADDR_TOP, 32'h0000_0008);
    load(2'h0, 16'h8003);
    load(2'h1, 16'h8000);
    load(2'h2, 16'h8008);
    load(2'h3, 16'h0003);
    commit();
    apb(1'b1, `PWM_ADDR_TASK, 32'h0000_0001);
    meas(3, 16'd8, 64'h0005_0008_0000_0003);
    apb(1'b1, `PWM_ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, `PWM_ADDR_PRESCALE, 32'h0000_0001);
    load(2'h2, 16'h800C);
    commit();
    repeat (2) @(posedge mclk iff period_start);
    apb(1'b1, `PWM_ADDR_TOP, 32'h0000_0014);
    meas(2, 16'd32, 64'h0016_0020_0000_000A);
    apb(1'b1, `PWM_ADDR_CTRL, 32'h0000_0006);
    apb(1'b1, `PWM_ADDR_PRESCALE, 32'h0000_0000);
    load(2'h0, 16'h8002);
    load(2'h3, 16'h0006);
    commit();
    meas(3, 16'd6, 64'h0000_0006_0000_0002);
    apb(1'b1, `PWM_ADDR_TASK, 32'h0000_0002);
    repeat (20) @(posedge mclk);
    chk("pwm_out", 32'h0000_0000, {28'h0, pwm_out});
    summarize();
  end

  initial
  begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    summarize();
  end
endmodule : tb
